//--- design/acmp_ctrl.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module acmp_ctrl (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Register port
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // Analog comparator core
   input  wire logic       cmp_out_i,
   output logic            cmp_power_off_o,
   output logic            cmp_ref_select_o,
   output logic            ref_enable_o,
   // Processor interrupt handshake
   input  wire logic       global_irq_en_i,
   input  wire logic       vector_ack_i,
   output logic            cmp_irq_req_o,
   // Timer input capture
   output logic            capture_src_o,
   output logic            capture_sel_o,
   // Shared pins and second serial port
   input  wire logic       serial1_tx_en_i,
   input  wire logic       serial1_rx_en_i,
   output logic            serial1_owns_pins_o,
   // Block interrupt
   output logic            irq_o
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   acmp_pkg::acmp_ctrl_t ctrl_r;
   acmp_pkg::acmp_ctrl_t ctrl_nxt;
   logic                 flag_r;
   logic                 flag_nxt;
   logic [7:0]           stat_r;
   logic [7:0]           stat_nxt;
   logic [7:0]           mask_r;
   logic [7:0]           rdata_r;
   logic [7:0]           rdata_nxt;

   logic                 result;
   acmp_pkg::acmp_edge_t edges;

   localparam acmp_pkg::acmp_ctrl_t CTRL_RST_FIELDS = '{
      power_off:     acmp_pkg::CTRL_RST[acmp_pkg::POWER_OFF_BIT],
      ref_select:    acmp_pkg::CTRL_RST[acmp_pkg::REF_SEL_BIT],
      capture_route: acmp_pkg::CTRL_RST[acmp_pkg::CAP_ROUTE_BIT],
      irq_enable:    acmp_pkg::CTRL_RST[acmp_pkg::IRQ_EN_BIT],
      mode:          acmp_pkg::acmp_mode_t'(
         acmp_pkg::CTRL_RST[acmp_pkg::MODE_HI_BIT:acmp_pkg::MODE_LO_BIT])
   };

   // ----------------------------------------------------------------
   // Synchroniser and edges
   // ----------------------------------------------------------------
   // The analog core makes the comparison; this block only carries its result.
   acmp_edge_det u_edge (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .raw_i     (cmp_out_i),
      .level_o   (result),
      .edge_o    (edges)
   );

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic mode_hit(input acmp_pkg::acmp_mode_t m,
                                     input acmp_pkg::acmp_edge_t e);
      logic hit;
      hit = 1'b0;
      unique case (m)
         acmp_pkg::ACMP_MODE_TOGGLE:   hit = e.toggle;
         acmp_pkg::ACMP_MODE_RESERVED: hit = 1'b0;
         acmp_pkg::ACMP_MODE_FALL:     hit = e.fall;
         acmp_pkg::ACMP_MODE_RISE:     hit = e.rise;
      endcase
      return hit;
   endfunction : mode_hit

   wire        wr_ctrl   = reg_wr_i && (reg_addr_i == acmp_pkg::CTRL_OFS);
   wire        wr_stat   = reg_wr_i && (reg_addr_i == acmp_pkg::IRQ_STAT_OFS);
   wire        wr_mask   = reg_wr_i && (reg_addr_i == acmp_pkg::IRQ_MASK_OFS);
   // Events are ignored while powered off, so powering off cannot flag; powering back on can.
   wire        event_hit = ~ctrl_r.power_off & mode_hit(ctrl_r.mode, edges);
   wire        flag_clr  = (wr_ctrl && reg_wdata_i[acmp_pkg::IRQ_FLAG_BIT])
                           || vector_ack_i;
   wire [7:0]  ctrl_view = {ctrl_r.power_off, ctrl_r.ref_select, result, flag_r,
                            ctrl_r.irq_enable, ctrl_r.capture_route,
                            ctrl_r.mode};

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt.power_off     = reg_wdata_i[acmp_pkg::POWER_OFF_BIT];
         ctrl_nxt.ref_select    = reg_wdata_i[acmp_pkg::REF_SEL_BIT];
         ctrl_nxt.irq_enable    = reg_wdata_i[acmp_pkg::IRQ_EN_BIT];
         ctrl_nxt.capture_route = reg_wdata_i[acmp_pkg::CAP_ROUTE_BIT];
         ctrl_nxt.mode = acmp_pkg::acmp_mode_t'(
            reg_wdata_i[acmp_pkg::MODE_HI_BIT:acmp_pkg::MODE_LO_BIT]);
      end
   end

   // Set wins over clear so an event in the clearing cycle is kept.
   assign flag_nxt = event_hit | (flag_r & ~flag_clr);

   always_comb begin
      stat_nxt = stat_r;
      if (wr_stat) begin
         stat_nxt = stat_r & ~reg_wdata_i;
      end
      if (event_hit) begin
         stat_nxt[acmp_pkg::STAT_EVENT_BIT] = 1'b1;
      end
   end

   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            acmp_pkg::CTRL_OFS:     rdata_nxt = ctrl_view;
            acmp_pkg::IRQ_STAT_OFS: rdata_nxt = stat_r;
            acmp_pkg::IRQ_MASK_OFS: rdata_nxt = mask_r;
            default:                rdata_nxt = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_r  <= CTRL_RST_FIELDS;
         flag_r  <= acmp_pkg::CTRL_RST[acmp_pkg::IRQ_FLAG_BIT];
         stat_r  <= acmp_pkg::IRQ_STAT_RST;
         mask_r  <= acmp_pkg::IRQ_MASK_RST;
         rdata_r <= 8'h00;
      end else begin
         ctrl_r  <= ctrl_nxt;
         flag_r  <= flag_nxt;
         stat_r  <= stat_nxt;
         mask_r  <= wr_mask ? reg_wdata_i : mask_r;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o         = rdata_r;
   assign cmp_power_off_o     = ctrl_r.power_off;
   assign cmp_ref_select_o    = ctrl_r.ref_select;
   // The reference is only powered while selected, to save supply current.
   assign ref_enable_o        = ctrl_r.ref_select;
   assign cmp_irq_req_o       = flag_r & ctrl_r.irq_enable & global_irq_en_i;
   // Gated to zero when not routed, so timer capture sees no stray edges.
   assign capture_src_o       = ctrl_r.capture_route & result;
   assign capture_sel_o       = ctrl_r.capture_route;
   assign serial1_owns_pins_o = serial1_tx_en_i | serial1_rx_en_i;
   assign irq_o               = |(stat_r & mask_r);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_req_gating: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmp_irq_req_o == (flag_r && ctrl_r.irq_enable && global_irq_en_i))
      else $error("Interrupt request not gated correctly.");

   a_flag_sets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      event_hit |=> flag_r)
      else $error("Flag did not set after event.");

   a_w1c_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wr_ctrl && reg_wdata_i[acmp_pkg::IRQ_FLAG_BIT] && !event_hit) |=> !flag_r)
      else $error("Flag not cleared by write of one.");

   a_w0_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (flag_r && !vector_ack_i && !(wr_ctrl && reg_wdata_i[acmp_pkg::IRQ_FLAG_BIT]))
      |=> flag_r)
      else $error("Flag lost without a clear.");

   a_vector_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (vector_ack_i && !event_hit) |=> !flag_r)
      else $error("Vector did not clear flag.");

   a_reserved_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_r.mode == acmp_pkg::ACMP_MODE_RESERVED) |-> !event_hit)
      else $error("Reserved mode produced an event.");

   a_rise_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_r.mode == acmp_pkg::ACMP_MODE_RISE && !ctrl_r.power_off && $rose(result))
      |-> event_hit)
      else $error("Rising edge missed.");

   a_fall_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_r.mode == acmp_pkg::ACMP_MODE_FALL && !ctrl_r.power_off && $fell(result))
      |-> event_hit)
      else $error("Falling edge missed.");

   a_toggle_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_r.mode == acmp_pkg::ACMP_MODE_TOGGLE && !ctrl_r.power_off && $changed(result))
      |-> event_hit)
      else $error("Toggle missed.");

   a_off_no_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_r.power_off && !flag_r) |=> !flag_r)
      else $error("Flag set while comparator powered off.");

   a_flag_needs_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!flag_r && !event_hit) |=> !flag_r)
      else $error("Flag set without an event.");

   a_stat_sets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      event_hit |=> stat_r[acmp_pkg::STAT_EVENT_BIT])
      else $error("Status bit did not set after event.");

   a_stat_w1c: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wr_stat && reg_wdata_i[acmp_pkg::STAT_EVENT_BIT] && !event_hit)
      |=> !stat_r[acmp_pkg::STAT_EVENT_BIT])
      else $error("Status bit not cleared by write of one.");

   a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (stat_r[acmp_pkg::STAT_EVENT_BIT] && mask_r[acmp_pkg::STAT_EVENT_BIT]) |-> irq_o)
      else $error("Unmasked status without interrupt.");

   a_mask_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_mask |=> mask_r == $past(reg_wdata_i))
      else $error("Mask write not applied.");

   a_result_live: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i == acmp_pkg::CTRL_OFS)
      |=> reg_rdata_o[acmp_pkg::RESULT_BIT] == $past(result))
      else $error("Result bit does not follow comparator.");

   a_rdata_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("Read data present without a read.");

   a_unmapped_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_rd_i && reg_addr_i > acmp_pkg::IRQ_MASK_OFS)
      |=> reg_rdata_o == 8'h00)
      else $error("Unmapped read returned data.");

   a_capture_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_r.capture_route |-> (!capture_src_o && !capture_sel_o))
      else $error("Capture path not isolated.");

   a_capture_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ctrl_r.capture_route |-> (capture_src_o == result && capture_sel_o))
      else $error("Capture path does not carry the result.");

   a_power_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_ctrl |=> cmp_power_off_o == $past(reg_wdata_i[acmp_pkg::POWER_OFF_BIT]))
      else $error("Power-off bit not applied.");

   a_ref_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_ctrl |=> cmp_ref_select_o == $past(reg_wdata_i[acmp_pkg::REF_SEL_BIT]))
      else $error("Reference select not applied.");

   a_mode_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_ctrl |=> ctrl_r.mode ==
         $past(reg_wdata_i[acmp_pkg::MODE_HI_BIT:acmp_pkg::MODE_LO_BIT]))
      else $error("Mode field not applied.");

   a_enable_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_ctrl |=> ctrl_r.irq_enable == $past(reg_wdata_i[acmp_pkg::IRQ_EN_BIT]))
      else $error("Interrupt enable not applied.");

   a_ctrl_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !wr_ctrl |=> $stable(ctrl_r))
      else $error("Control fields changed without a write.");

   a_enable_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_r.irq_enable |-> !cmp_irq_req_o)
      else $error("Request while interrupt disabled.");

   a_global_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !global_irq_en_i |-> !cmp_irq_req_o)
      else $error("Request while global enable off.");

   a_pin_override: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (serial1_tx_en_i || serial1_rx_en_i) |-> serial1_owns_pins_o)
      else $error("Serial port lost pin control.");

endmodule : acmp_ctrl

//--- design/acmp_edge_det.sv
// Synchroniser and edge detector for the comparator output.
`timescale 1ns/1ps
module acmp_edge_det (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Comparator output from the analog core
   input  wire logic             raw_i,
   // Synchronised level and events
   output logic                  level_o,
   output acmp_pkg::acmp_edge_t  edge_o
);

   logic sync1_r;
   logic sync2_r;
   logic prev_r;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end else begin
         sync1_r <= raw_i;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   assign level_o       = sync2_r;
   assign edge_o.rise   = sync2_r & ~prev_r;
   assign edge_o.fall   = ~sync2_r & prev_r;
   assign edge_o.toggle = sync2_r ^ prev_r;

endmodule : acmp_edge_det

//--- design/acmp_pkg.sv
// Package with register layout, reset values and types for the comparator control block.
package acmp_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS      = 4'h0;
   localparam logic [3:0] IRQ_STAT_OFS  = 4'h1;
   localparam logic [3:0] IRQ_MASK_OFS  = 4'h2;

   // ----------------------------------------------------------------
   // Control/status field positions
   // ----------------------------------------------------------------
   localparam int POWER_OFF_BIT  = 7;
   localparam int REF_SEL_BIT    = 6;
   localparam int RESULT_BIT     = 5;
   localparam int IRQ_FLAG_BIT   = 4;
   localparam int IRQ_EN_BIT     = 3;
   localparam int CAP_ROUTE_BIT  = 2;
   localparam int MODE_HI_BIT    = 1;
   localparam int MODE_LO_BIT    = 0;

   // Own status/mask layout: bit 0 is the comparator event.
   localparam int STAT_EVENT_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RST      = 8'h00;
   localparam logic [7:0] IRQ_STAT_RST  = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ACMP_MODE_TOGGLE   = 2'h0,
      ACMP_MODE_RESERVED = 2'h1,
      ACMP_MODE_FALL     = 2'h2,
      ACMP_MODE_RISE     = 2'h3
   } acmp_mode_t;

   typedef struct packed {
      logic       power_off;
      logic       ref_select;
      logic       capture_route;
      logic       irq_enable;
      acmp_mode_t mode;
   } acmp_ctrl_t;

   typedef struct packed {
      logic rise;
      logic fall;
      logic toggle;
   } acmp_edge_t;

endpackage : acmp_pkg

//--- dv/acmp_core_model.sv
// Behavioural model of the analog comparator core and its internal reference.
`timescale 1ns/1ps
module acmp_core_model #(
   parameter int REF_MV    = 1220,
   parameter int REF_START = 8
) (
   // Clock
   input  wire logic clk_i,
   // Pin voltages in millivolts
   input  int        pos_mv_i,
   input  int        neg_mv_i,
   // Controls from the block
   input  wire logic power_off_i,
   input  wire logic ref_select_i,
   input  wire logic ref_enable_i,
   // Comparator output
   output logic      cmp_out_o
);
   int ref_age = 0;
   int pos_mv;
   // The reference reads as 0 mV until it has run REF_START cycles.
   always @(posedge clk_i) ref_age <= ref_enable_i ? ref_age + 1 : 0;
   assign pos_mv = !ref_select_i ? pos_mv_i : (ref_age >= REF_START ? REF_MV : 0);
   // An unpowered comparator gives a low output.
   assign cmp_out_o = !power_off_i && (pos_mv > neg_mv_i);
endmodule : acmp_core_model

//--- dv/test_acmp_ctrl.sv
// Self-checking testbench for the comparator control block.
`timescale 1ns/1ps
module test_acmp_ctrl;
   localparam logic [3:0] CT = acmp_pkg::CTRL_OFS;
   localparam logic [3:0] ST = acmp_pkg::IRQ_STAT_OFS;
   localparam logic [3:0] MK = acmp_pkg::IRQ_MASK_OFS;
   logic       clk_i           = 1'b0;
   logic       sys_rst_i       = 1'b1;
   logic [3:0] reg_addr_i      = 4'h0;
   logic [7:0] reg_wdata_i     = 8'h00;
   logic       reg_wr_i        = 1'b0;
   logic       reg_rd_i        = 1'b0;
   logic       global_irq_en_i = 1'b0;
   logic       vector_ack_i    = 1'b0;
   logic       serial1_tx_en_i = 1'b0;
   logic       serial1_rx_en_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic       cmp_out_i, cmp_power_off_o, cmp_ref_select_o, ref_enable_o;
   logic       cmp_irq_req_o, capture_src_o, capture_sel_o, serial1_owns_pins_o, irq_o;
   int         pos_mv     = 0;
   int         neg_mv     = 500;
   int         seed       = 74;
   int         fail_count = 0;
   int         checked    = 0;
   logic       rd_q       = 1'b0;
   logic [7:0] md;
   logic [7:0] exp_q[$];

   acmp_core_model core_u (.clk_i(clk_i), .pos_mv_i(pos_mv), .neg_mv_i(neg_mv),
      .power_off_i(cmp_power_off_o), .ref_select_i(cmp_ref_select_o),
      .ref_enable_i(ref_enable_o), .cmp_out_o(cmp_out_i));
   acmp_ctrl dut_u (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .cmp_out_i, .cmp_power_off_o, .cmp_ref_select_o, .ref_enable_o,
      .global_irq_en_i, .vector_ack_i, .cmp_irq_req_o, .capture_src_o, .capture_sel_o,
      .serial1_tx_en_i, .serial1_rx_en_i, .serial1_owns_pins_o, .irq_o);

   initial forever #12.5 clk_i = ~clk_i;

   // ----------------------------------------------------------------
   // Bus tasks and comparisons
   // ----------------------------------------------------------------
   task automatic fail_msg(input string msg);
      fail_count++;
      $display("FAIL %0t %s", $time, msg);
   endtask : fail_msg
   // The signal is read by reference after the delay, once the edge's updates settle.
   task automatic chk_bit(ref logic got, input logic exp, input string what);
      #1;
      checked++;
      if (got !== exp) fail_msg(what);
   endtask : chk_bit
   task automatic chk_rd(input logic [7:0] exp);
      checked++;
      if (reg_rdata_o !== exp) fail_msg($sformatf("read %h expected %h", reg_rdata_o, exp));
   endtask : chk_rd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
   endtask : rd
   task automatic set_pos(input int mv);
      @(posedge clk_i);
      pos_mv <= mv;
      cyc(5);
   endtask : set_pos
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // Read data stand only in the cycle after the strobe.
   always @(posedge clk_i) rd_q <= reg_rd_i;
   always @(negedge clk_i) begin
      if (rd_q) chk_rd(exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      cyc(2);
      sys_rst_i <= 1'b0;
      chk_bit(irq_o, 1'b0, "irq after reset");
      rd(CT, acmp_pkg::CTRL_RST);
      rd(ST, acmp_pkg::IRQ_STAT_RST);
      rd(MK, acmp_pkg::IRQ_MASK_RST);
      wr(4'hF, 8'($random(seed)));
      rd(4'hF, 8'h00);
      rd(CT, 8'h00);
      for (int m = 0; m < 4; m++) begin
         md = 8'(m);
         wr(CT, 8'h10 | md);
         set_pos(600 + {$random(seed)} % 400);
         rd(CT, 8'h20 | md | ((m == 0 || m == 3) ? 8'h10 : 8'h00));
         wr(CT, 8'h10 | md);
         set_pos(0);
         rd(CT, md | ((m == 0 || m == 2) ? 8'h10 : 8'h00));
      end
      wr(ST, 8'hFF);
      wr(MK, 8'h01);
      wr(CT, 8'h1B);
      chk_bit(irq_o, 1'b0, "irq without event");
      set_pos(900);
      chk_bit(cmp_irq_req_o, 1'b0, "request with global off");
      chk_bit(irq_o, 1'b1, "irq on unmasked event");
      @(posedge clk_i);
      global_irq_en_i <= 1'b1;
      chk_bit(cmp_irq_req_o, 1'b1, "request missing");
      wr(CT, 8'h03);
      chk_bit(cmp_irq_req_o, 1'b0, "request while disabled");
      wr(CT, 8'h0B);
      chk_bit(cmp_irq_req_o, 1'b1, "flag lost on zero write");
      @(posedge clk_i);
      vector_ack_i <= 1'b1;
      @(posedge clk_i);
      vector_ack_i <= 1'b0;
      chk_bit(cmp_irq_req_o, 1'b0, "flag kept after vector");
      rd(CT, 8'h2B);
      wr(MK, 8'h00);
      chk_bit(irq_o, 1'b0, "irq while masked");
      wr(MK, 8'h01);
      chk_bit(irq_o, 1'b1, "irq after unmask");
      wr(ST, 8'h01);
      chk_bit(irq_o, 1'b0, "irq after status clear");
      rd(ST, 8'h00);
      set_pos(0);
      set_pos(900);
      rd(CT, 8'h3B);
      wr(CT, 8'h1B);
      rd(CT, 8'h2B);
      global_irq_en_i <= 1'b0;
      wr(CT, 8'h01);
      wr(CT, 8'h05);
      chk_bit(capture_src_o, 1'b1, "capture not routed");
      chk_bit(capture_sel_o, 1'b1, "capture select low");
      wr(CT, 8'h01);
      chk_bit(capture_src_o, 1'b0, "capture leaks");
      chk_bit(capture_sel_o, 1'b0, "capture select leaks");
      @(posedge clk_i);
      pos_mv <= 0;
      neg_mv <= 1000;
      wr(CT, 8'h41);
      chk_bit(ref_enable_o, 1'b1, "reference unpowered");
      chk_bit(cmp_ref_select_o, 1'b1, "reference not selected");
      cyc(12);
      rd(CT, 8'h61);
      wr(CT, 8'hC1);
      chk_bit(cmp_power_off_o, 1'b1, "power-off low");
      cyc(4);
      rd(CT, 8'hC1);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      chk_bit(cmp_power_off_o, 1'b0, "power-off after reset");
      rd(CT, 8'h00);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_i);
         serial1_tx_en_i <= s[0];
         serial1_rx_en_i <= s[1];
         @(posedge clk_i);
         chk_bit(serial1_owns_pins_o, s != 0, "pin ownership");
      end
      for (int i = 0; i < 4 && exp_q.size() > 0; i++) @(posedge clk_i);
      if (exp_q.size() > 0) fail_msg("reads left unanswered");
      end_sim();
   end
endmodule : test_acmp_ctrl
